// ---- src/lfo_pkg.sv ----
package lfo_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned LF_HZ             = 80_000;
    localparam int unsigned LF_HALF_CYC       = CLK_HZ / (2 * LF_HZ);
    localparam int unsigned LF_TUNE_STEP_CYC  = 4;
    localparam int unsigned LF_TUNE_MID       = 8;
    localparam int unsigned LF_READY_CYCLES   = 16;
    localparam int unsigned SYNC_TIMER_CLOCKS = 3;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [11:0] IDX_HF_CTRL    = 12'h0B2;
    localparam logic [11:0] IDX_LF_CTRL    = 12'h0E3;
    localparam logic [11:0] IDX_CLK_SRC    = 12'h010;
    localparam logic [11:0] IDX_CAP_CTRL   = 12'h011;
    localparam logic [11:0] IDX_T2_RELOAD  = 12'h012;
    localparam logic [11:0] IDX_T3_RELOAD  = 12'h013;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h014;
    localparam logic [11:0] IDX_IRQ_MASK   = 12'h015;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int unsigned LF_EN_BIT   = 7;
    localparam int unsigned LF_RDY_BIT  = 6;
    localparam int unsigned LF_TUNE_LSB = 2;
    localparam int unsigned LF_DIV_LSB  = 0;
    localparam int unsigned HF_SYNC_BIT = 4;
    localparam int unsigned HF_DIV_LSB  = 0;
    localparam logic [3:0]  LF_TUNE_RST = 4'h8;
    localparam logic [1:0]  LF_DIV_RST  = 2'h0;
    localparam logic [1:0]  HF_DIV_RST  = 2'h0;

    localparam logic [1:0] SRC_HF_DIV  = 2'h0;
    localparam logic [1:0] SRC_LF      = 2'h1;
    localparam logic [1:0] SRC_LP      = 2'h2;
    localparam logic [1:0] SRC_HF_FULL = 2'h3;

    localparam int unsigned IRQ_LF_READY  = 0;
    localparam int unsigned IRQ_T2_CAP    = 1;
    localparam int unsigned IRQ_T3_CAP    = 2;
    localparam int unsigned IRQ_SYNC_DONE = 3;
    localparam int unsigned IRQ_W         = 4;

    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b01,
        SYNC_WAIT = 2'b10
    } lfo_sync_t;

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic logic lfoHit(input logic [11:0] addr, input logic [11:0] idx);
        return addr == {idx[9:0], 2'b00};
    endfunction

    function automatic logic [4:0] lfoHfRatio(input logic [1:0] code);
        case (code)
            2'h0:    return 5'h10;
            2'h1:    return 5'h08;
            2'h2:    return 5'h04;
            default: return 5'h02;
        endcase
    endfunction

    function automatic logic [3:0] lfoLfRatio(input logic [1:0] code);
        case (code)
            2'h0:    return 4'h8;
            2'h1:    return 4'h4;
            2'h2:    return 4'h2;
            default: return 4'h1;
        endcase
    endfunction

endpackage

// ---- src/lfo_lf_osc.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfo_lf_osc
    import lfo_pkg::*;
#(
    parameter int unsigned READY_CYCLES = LF_READY_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       oscEnable,
    input  wire logic [3:0] fineTune,
    input  wire logic [1:0] divSel,
    input  wire logic       divChange,
    output logic            oscOut,
    output logic            ready
);

    typedef struct packed {
        logic [9:0] halfCnt;
        logic [2:0] divCnt;
        logic       out;
        logic [7:0] rdyCnt;
        logic       ready;
    } lfo_osc_t;

    lfo_osc_t osc_q;
    lfo_osc_t osc_d;
    logic [9:0] halfLen;
    logic       halfTick;

    // Period grows with the tune code: 0 fastest, 15 slowest
    assign halfLen = 10'(LF_HALF_CYC - LF_TUNE_MID * LF_TUNE_STEP_CYC
                         + int'(fineTune) * LF_TUNE_STEP_CYC);
    assign halfTick = oscEnable && (osc_q.halfCnt >= halfLen - 10'h001);

    always_comb begin
        osc_d = osc_q;
        if (!oscEnable) begin
            osc_d.halfCnt = 10'h000;
            osc_d.divCnt  = 3'h0;
            osc_d.out     = 1'b0;
        end else if (halfTick) begin
            osc_d.halfCnt = 10'h000;
            if ({1'b0, osc_q.divCnt} >= lfoLfRatio(divSel) - 4'h1) begin
                osc_d.divCnt = 3'h0;
                osc_d.out    = !osc_q.out;
            end else begin
                osc_d.divCnt = osc_q.divCnt + 3'h1;
            end
            // Half ticks counted, so the limit is twice the cycle count
            if (!osc_q.ready) begin
                if (osc_q.rdyCnt >= 8'(2 * READY_CYCLES - 1)) begin
                    osc_d.ready = 1'b1;
                end else begin
                    osc_d.rdyCnt = osc_q.rdyCnt + 8'h01;
                end
            end
        end else begin
            osc_d.halfCnt = osc_q.halfCnt + 10'h001;
        end
        // Disable alone leaves ready set; only reset or a divider change drops it
        if (divChange) begin
            osc_d.ready  = 1'b0;
            osc_d.rdyCnt = 8'h00;
            osc_d.divCnt = 3'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_q <= '0;
        end else begin
            osc_q <= osc_d;
        end
    end

    assign oscOut = osc_q.out;
    assign ready  = osc_q.ready;

endmodule
`default_nettype wire

// ---- src/lfo_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfo_capture
    import lfo_pkg::*;
#(
    parameter bit FALLING = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        capMode,
    input  wire logic        oscOut,
    input  wire logic [15:0] count,
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    output logic [15:0]      reload,
    output logic             capEvent
);

    typedef struct packed {
        logic        prev;
        logic [15:0] reload;
        logic        evt;
    } lfo_cap_t;

    lfo_cap_t cap_q;
    lfo_cap_t cap_d;
    logic     edgeSeen;

    assign edgeSeen = FALLING ? (cap_q.prev && !oscOut)
                              : (!cap_q.prev && oscOut);

    always_comb begin
        cap_d      = cap_q;
        cap_d.prev = oscOut;
        cap_d.evt  = 1'b0;
        if (wrEn) begin
            cap_d.reload = wrData;
        end
        // Capture beats a software write in the same cycle
        if (capMode && edgeSeen) begin
            cap_d.reload = count;
            cap_d.evt    = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cap_q <= '0;
        end else begin
            cap_q <= cap_d;
        end
    end

    assign reload   = cap_q.reload;
    assign capEvent = cap_q.evt;

endmodule
`default_nettype wire

// ---- src/lfo_clock_ctrl.sv ----
// Behaviour
// - Sync flag high up to three timer clocks
// - HF control bits 3:2 read zero
// - HF divider code selects 16/8/4/2
// - HF divider only affects divided source
// - LF oscillator nominal 80 kHz, post-divided
// - LF divider code selects 8/4/2/1
// - Tune 0000 fastest, 1111 slowest
// - Enable bit starts and stops LF oscillator
// - Ready bit reports stabilized LF oscillator
// - Ready clears only on reset or divider change
// - Timer 2 falling, timer 3 rising capture
// - Capture copies count into reload pair
// - Low-power oscillator on only when selected
`timescale 1ns/1ps
`default_nettype none
module lfo_clock_ctrl
    import lfo_pkg::*;
#(
    parameter int unsigned READY_CYCLES = LF_READY_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        suspendWake,
    input  wire logic        wakeTimerTick,
    input  wire logic        lpOscTick,
    input  wire logic [15:0] t2Count,
    input  wire logic [15:0] t3Count,
    output logic             sysClkTick,
    output logic             lfOscOut,
    output logic             lpOscEnable,
    output logic             irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic             lfEn;
        logic [3:0]       lfTune;
        logic [1:0]       lfDiv;
        logic [1:0]       hfDiv;
        logic [1:0]       clkSrc;
        logic [1:0]       capMode;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        lfo_sync_t        sync;
        logic [1:0]       syncCnt;
        logic [3:0]       hfCnt;
        logic             sysTick;
        logic             lfPrev;
        logic             rdyPrev;
        // Registered so prdata cannot glitch
        logic [31:0]      rdata;
    } lfo_ctrl_t;

    lfo_ctrl_t ctl_q;
    lfo_ctrl_t ctl_d;

    logic        wrEn;
    logic        rdSetup;
    logic        mapped;
    logic        lfWrite;
    logic        divChange;
    logic        lfOut;
    logic        lfReady;
    logic        hfTick;
    logic        syncFlag;
    logic [31:0] readMux;
    logic [4:0]  hfRatio;
    logic [1:0]  capEvent;
    logic [15:0] capCount [2];
    logic [15:0] capReload [2];
    logic [1:0]  capWr;
    logic [IRQ_W-1:0] irqSet;

    // ************************************************************
    // APB decode
    // ************************************************************
    assign wrEn    = psel && penable && pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign mapped  = lfoHit(paddr, IDX_HF_CTRL)    || lfoHit(paddr, IDX_LF_CTRL)
                  || lfoHit(paddr, IDX_CLK_SRC)    || lfoHit(paddr, IDX_CAP_CTRL)
                  || lfoHit(paddr, IDX_T2_RELOAD)  || lfoHit(paddr, IDX_T3_RELOAD)
                  || lfoHit(paddr, IDX_IRQ_STATUS) || lfoHit(paddr, IDX_IRQ_MASK);
    // No wait states; read data is caught in the setup cycle
    assign pready  = 1'b1;
    // Unmapped: error, reads zero
    assign pslverr = psel && penable && !mapped;

    assign lfWrite   = wrEn && lfoHit(paddr, IDX_LF_CTRL);
    // Same-value rewrite keeps ready
    assign divChange = lfWrite
                    && (pwdata[LF_DIV_LSB +: 2] != ctl_q.lfDiv);
    assign capWr[0]  = wrEn && lfoHit(paddr, IDX_T2_RELOAD);
    assign capWr[1]  = wrEn && lfoHit(paddr, IDX_T3_RELOAD);
    assign capCount[0] = t2Count;
    assign capCount[1] = t3Count;

    // Hardware clears; software only polls
    assign syncFlag  = (ctl_q.sync == SYNC_WAIT);

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        readMux = 32'h0000_0000;
        if (lfoHit(paddr, IDX_HF_CTRL)) begin
            // Bits 3:2 are never stored and always read zero
            readMux[HF_SYNC_BIT]       = syncFlag;
            readMux[HF_DIV_LSB +: 2]   = ctl_q.hfDiv;
        end else if (lfoHit(paddr, IDX_LF_CTRL)) begin
            readMux[LF_EN_BIT]         = ctl_q.lfEn;
            readMux[LF_RDY_BIT]        = lfReady;
            readMux[LF_TUNE_LSB +: 4]  = ctl_q.lfTune;
            readMux[LF_DIV_LSB +: 2]   = ctl_q.lfDiv;
        end else if (lfoHit(paddr, IDX_CLK_SRC)) begin
            readMux[1:0] = ctl_q.clkSrc;
        end else if (lfoHit(paddr, IDX_CAP_CTRL)) begin
            readMux[1:0] = ctl_q.capMode;
        end else if (lfoHit(paddr, IDX_T2_RELOAD)) begin
            readMux[15:0] = capReload[0];
        end else if (lfoHit(paddr, IDX_T3_RELOAD)) begin
            readMux[15:0] = capReload[1];
        end else if (lfoHit(paddr, IDX_IRQ_STATUS)) begin
            readMux[IRQ_W-1:0] = ctl_q.irqStat;
        end else if (lfoHit(paddr, IDX_IRQ_MASK)) begin
            readMux[IRQ_W-1:0] = ctl_q.irqMask;
        end
    end

    // ************************************************************
    // HF divider
    // ************************************************************
    assign hfRatio = lfoHfRatio(ctl_q.hfDiv);
    assign hfTick  = ({1'b0, ctl_q.hfCnt} >= hfRatio - 5'h01);

    // ************************************************************
    // Event collection
    // ************************************************************
    always_comb begin
        irqSet                = '0;
        // Rising edge only, no refire
        irqSet[IRQ_LF_READY]  = lfReady && !ctl_q.rdyPrev;
        irqSet[IRQ_T2_CAP]    = capEvent[0];
        irqSet[IRQ_T3_CAP]    = capEvent[1];
        irqSet[IRQ_SYNC_DONE] = syncFlag && wakeTimerTick && !suspendWake
                             && (ctl_q.syncCnt == 2'(SYNC_TIMER_CLOCKS - 1));
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        ctl_d         = ctl_q;
        ctl_d.rdyPrev = lfReady;
        ctl_d.lfPrev  = lfOut;

        // Caught at setup so access needs no wait
        if (rdSetup) begin
            ctl_d.rdata = readMux;
        end

        if (wrEn) begin
            if (lfoHit(paddr, IDX_HF_CTRL)) begin
                ctl_d.hfDiv = pwdata[HF_DIV_LSB +: 2];
            end
            if (lfWrite) begin
                ctl_d.lfEn   = pwdata[LF_EN_BIT];
                // Tune is taken at any time; firmware keeps it to disabled periods
                ctl_d.lfTune = pwdata[LF_TUNE_LSB +: 4];
                ctl_d.lfDiv  = pwdata[LF_DIV_LSB +: 2];
            end
            if (lfoHit(paddr, IDX_CLK_SRC)) begin
                ctl_d.clkSrc = pwdata[1:0];
            end
            if (lfoHit(paddr, IDX_CAP_CTRL)) begin
                ctl_d.capMode = pwdata[1:0];
            end
            if (lfoHit(paddr, IDX_IRQ_MASK)) begin
                ctl_d.irqMask = pwdata[IRQ_W-1:0];
            end
            if (lfoHit(paddr, IDX_IRQ_STATUS)) begin
                ctl_d.irqStat = ctl_q.irqStat & ~pwdata[IRQ_W-1:0];
            end
        end
        // Set after clear so a same-cycle event is kept
        ctl_d.irqStat = ctl_d.irqStat | irqSet;

        // Wake timer handshake
        case (ctl_q.sync)
            SYNC_IDLE: begin
                if (suspendWake) begin
                    ctl_d.sync    = SYNC_WAIT;
                    ctl_d.syncCnt = 2'h0;
                end
            end
            SYNC_WAIT: begin
                // A fresh wake source restarts
                if (suspendWake) begin
                    ctl_d.syncCnt = 2'h0;
                end else if (wakeTimerTick) begin
                    if (ctl_q.syncCnt == 2'(SYNC_TIMER_CLOCKS - 1)) begin
                        ctl_d.sync = SYNC_IDLE;
                    end else begin
                        ctl_d.syncCnt = ctl_q.syncCnt + 2'h1;
                    end
                end
            end
            default: begin
                ctl_d.sync = SYNC_IDLE;
            end
        endcase

        // HF post-divider runs on the main clock
        // Free-running; ratio change acts at once
        if (hfTick) begin
            ctl_d.hfCnt = 4'h0;
        end else begin
            ctl_d.hfCnt = ctl_q.hfCnt + 4'h1;
        end

        // System clock enable per selected source
        // LF ticks once per output rise
        case (ctl_q.clkSrc)
            SRC_HF_DIV:  ctl_d.sysTick = hfTick;
            SRC_LF:      ctl_d.sysTick = lfOut && !ctl_q.lfPrev;
            SRC_LP:      ctl_d.sysTick = lpOscTick;
            SRC_HF_FULL: ctl_d.sysTick = 1'b1;
            default:     ctl_d.sysTick = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q         <= '0;
            ctl_q.lfTune  <= LF_TUNE_RST;
            ctl_q.lfDiv   <= LF_DIV_RST;
            ctl_q.hfDiv   <= HF_DIV_RST;
            ctl_q.clkSrc  <= SRC_HF_DIV;
            ctl_q.sync    <= SYNC_IDLE;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // ************************************************************
    // LF oscillator and capture units
    // ************************************************************
    lfo_lf_osc #(
        .READY_CYCLES (READY_CYCLES)
    ) uOsc (
        .clk       (clk),
        .resetn    (resetn),
        .oscEnable (ctl_q.lfEn),
        .fineTune  (ctl_q.lfTune),
        .divSel    (ctl_q.lfDiv),
        .divChange (divChange),
        .oscOut    (lfOut),
        .ready     (lfReady)
    );

    // Timer 2 falling, timer 3 rising
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gCap
            lfo_capture #(
                .FALLING (g == 0)
            ) uCap (
                .clk      (clk),
                .resetn   (resetn),
                .capMode  (ctl_q.capMode[g]),
                .oscOut   (lfOut),
                .count    (capCount[g]),
                .wrEn     (capWr[g]),
                .wrData   (pwdata[15:0]),
                .reload   (capReload[g]),
                .capEvent (capEvent[g])
            );
        end
    endgenerate

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata      = ctl_q.rdata;
    assign sysClkTick  = ctl_q.sysTick;
    assign lfOscOut    = lfOut;
    // Powered only while selected
    assign lpOscEnable = (ctl_q.clkSrc == SRC_LP);
    // Level; drops once unmasked bits clear
    assign irq         = |(ctl_q.irqStat & ctl_q.irqMask);

endmodule
`default_nettype wire

// ---- testbench/lfo_clock_ctrl_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfo_clock_ctrl_monitor
    import lfo_pkg::*;
#(
    parameter int unsigned READY_CYCLES = LF_READY_CYCLES
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        lpOscTick,
    input wire logic        sysClkTick,
    input wire logic        lfOscOut,
    input wire logic        lpOscEnable
);
    // ************************************************************
    // Shadow of the clock source select
    // ************************************************************
    logic [1:0] srcQ;
    wire logic  srcWr = psel && penable && pwrite && paddr == {IDX_CLK_SRC[9:0], 2'b00};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            srcQ <= 2'h0;
        end else if (srcWr) begin
            srcQ <= pwdata[1:0];
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    no_wait_a: assert property (pready) else $error("pready low");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    lp_enable_a: assert property (lpOscEnable == (srcQ == SRC_LP))
        else $error("low-power enable differs from source");
    lp_tick_a: assert property (lpOscEnable && $past(lpOscEnable)
        |-> sysClkTick == $past(lpOscTick))
        else $error("low-power tick not passed on");
    full_tick_a: assert property (srcQ == SRC_HF_FULL && $past(srcQ) == SRC_HF_FULL
        |-> sysClkTick)
        else $error("undivided source missed a tick");
    div_gap_a: assert property (srcQ == SRC_HF_DIV && $past(srcQ) == SRC_HF_DIV
        && sysClkTick |=> !sysClkTick)
        else $error("divided ticks adjacent");
    hf_unused_a: assert property (psel && penable && !pwrite
        && paddr == {IDX_HF_CTRL[9:0], 2'b00} |-> prdata[3:2] == 2'h0 && prdata[31:5] == 27'h0)
        else $error("unused control bits read nonzero");
    lf_width_a: assert property ($rose(lfOscOut) |=> lfOscOut [*8])
        else $error("oscillator high phase too short");
endmodule

bind lfo_clock_ctrl lfo_clock_ctrl_monitor #(.READY_CYCLES(READY_CYCLES)) lfo_clock_ctrl_monitor_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lpOscTick(lpOscTick), .sysClkTick(sysClkTick), .lfOscOut(lfOscOut),
    .lpOscEnable(lpOscEnable));
`default_nettype wire

// ---- testbench/lfo_clock_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
    cmpCount++; \
    if ((gt) !== (ex)) begin \
        badCount++; \
        $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
    end \
end
module lfo_clock_ctrl_test
    import lfo_pkg::*;
;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} lfo_row_t;
    localparam int unsigned RDY   = 2;
    localparam int          HALF0 = LF_HALF_CYC - LF_TUNE_MID * LF_TUNE_STEP_CYC;
    localparam logic [11:0] A_HF  = {IDX_HF_CTRL[9:0], 2'b00};
    localparam logic [11:0] A_LF  = {IDX_LF_CTRL[9:0], 2'b00};
    localparam logic [11:0] A_SRC = {IDX_CLK_SRC[9:0], 2'b00};
    localparam logic [11:0] A_CAP = {IDX_CAP_CTRL[9:0], 2'b00};
    localparam logic [11:0] A_T2  = {IDX_T2_RELOAD[9:0], 2'b00};
    localparam logic [11:0] A_T3  = {IDX_T3_RELOAD[9:0], 2'b00};
    localparam logic [11:0] A_IST = {IDX_IRQ_STATUS[9:0], 2'b00};
    localparam logic [11:0] A_IMK = {IDX_IRQ_MASK[9:0], 2'b00};
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic        suspendWake, wakeTimerTick, lpOscTick, sysClkTick, lfOscOut, lpOscEnable, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, r1;
    logic [15:0] t2Count, t3Count, tk;
    int          badCount, cmpCount, n, hi;
    lfo_row_t    rows[8];
    lfo_row_t    rs[4];

    lfo_clock_ctrl #(.READY_CYCLES(RDY)) lfo_clock_ctrl_i (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .suspendWake(suspendWake), .wakeTimerTick(wakeTimerTick), .lpOscTick(lpOscTick),
        .t2Count(t2Count), .t3Count(t3Count), .sysClkTick(sysClkTick), .lfOscOut(lfOscOut),
        .lpOscEnable(lpOscEnable), .irq(irq));

    // ************************************************************
    // Clock, timers and tick sources
    // ************************************************************
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        tk <= tk + 16'h1;
        lpOscTick <= (tk % 3 == 0);
        wakeTimerTick <= (tk[2:0] == 3'h0);
        t2Count <= tk;
        t3Count <= tk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sel 0 watches the system tick, 1 the oscillator output
    task automatic waitLvl(input bit sel, input logic lvl);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel ? lfOscOut : sysClkTick) !== lvl && n < 5000);
    endtask

    task testDone;
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Bound well above the sequence length, far inside the run limit
    initial begin
        #1500000;
        badCount++;
        testDone;
    end

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        {clk, psel, penable, pwrite, suspendWake, wakeTimerTick, lpOscTick} = '0;
        {resetn, paddr, pwdata, t2Count, t3Count, tk, badCount, cmpCount} = '0;
        rows = '{'{A_HF, 32'hFF, 32'h3, 1'b0}, '{A_SRC, 32'hFFFFFFFF, 32'h3, 1'b0},
                 '{A_CAP, 32'h2, 32'h2, 1'b0}, '{A_T2, 32'hABCD1234, 32'h1234, 1'b0},
                 '{A_T3, 32'h5A5A, 32'h5A5A, 1'b0}, '{A_IMK, 32'hF, 32'hF, 1'b0},
                 '{12'hFFC, 32'h1, 32'h0, 1'b1}, '{A_LF, 32'h7E, 32'h3E, 1'b0}};
        rs = '{'{A_HF, 0, 32'h0, 1'b0}, '{A_LF, 0, 32'h20, 1'b0},
               '{A_SRC, 0, 32'h0, 1'b0}, '{A_IMK, 0, 32'h0, 1'b0}};
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            `CHK("readback", rows[i].e, rd)
            `CHK("slave error", rows[i].er, err)
        end
        // Reset in mid-run restores the register defaults
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (rs[i]) begin
            apb(1'b0, rs[i].a, 32'h0);
            `CHK("reset value", rs[i].e, rd)
        end
        apb(1'b1, A_SRC, 32'(SRC_HF_DIV));
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, A_HF, 32'(c));
            repeat (3) waitLvl(1'b0, 1'b1);
            `CHK("divided tick gap", 16 >> c, n)
        end
        apb(1'b1, A_SRC, 32'(SRC_HF_FULL));
        repeat (2) waitLvl(1'b0, 1'b1);
        `CHK("full tick gap", 1, n)
        apb(1'b1, A_SRC, 32'(SRC_LP));
        @(posedge clk);
        `CHK("low-power enable", 1'b1, lpOscEnable)
        repeat (2) waitLvl(1'b0, 1'b1);
        `CHK("low-power tick gap", 3, n)
        apb(1'b1, A_SRC, 32'(SRC_LF));
        @(posedge clk);
        `CHK("low-power disable", 1'b0, lpOscEnable)
        @(posedge clk) suspendWake <= 1'b1;
        @(posedge clk) suspendWake <= 1'b0;
        apb(1'b0, A_HF, 32'h0);
        `CHK("sync flag set", 1'b1, rd[4])
        repeat (30) @(posedge clk);
        apb(1'b0, A_HF, 32'h0);
        `CHK("sync flag clear", 1'b0, rd[4])
        apb(1'b0, A_IST, 32'h0);
        `CHK("sync status", 1'b1, rd[IRQ_SYNC_DONE])
        apb(1'b1, A_IST, 32'hF);
        apb(1'b1, A_IMK, 32'h1);
        apb(1'b1, A_CAP, 32'h3);
        apb(1'b1, A_LF, 32'h03);
        apb(1'b1, A_LF, 32'h83);
        waitLvl(1'b1, 1'b1);
        waitLvl(1'b1, 1'b0);
        `CHK("fast high phase", HALF0, n)
        waitLvl(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        apb(1'b0, A_T2, 32'h0);
        r1 = rd;
        apb(1'b0, A_T3, 32'h0);
        `CHK("rise minus fall", 16'(HALF0), 16'(rd[15:0] - r1[15:0]))
        r1 = rd;
        waitLvl(1'b1, 1'b0);
        waitLvl(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        apb(1'b0, A_T3, 32'h0);
        `CHK("capture period", 16'(2 * HALF0), 16'(rd[15:0] - r1[15:0]))
        apb(1'b0, A_LF, 32'h0);
        `CHK("ready set", 32'hC3, rd)
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, A_IST, 32'h1);
        @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, A_LF, 32'h83);
        apb(1'b0, A_LF, 32'h0);
        `CHK("ready kept", 32'hC3, rd)
        waitLvl(1'b1, 1'b0);
        apb(1'b1, A_LF, 32'h03);
        hi = 0;
        repeat (600) @(posedge clk) hi += int'(lfOscOut === 1'b1);
        `CHK("disabled output", 0, hi)
        apb(1'b0, A_LF, 32'h0);
        `CHK("ready after disable", 32'h43, rd)
        apb(1'b1, A_LF, 32'h01);
        apb(1'b0, A_LF, 32'h0);
        `CHK("ready dropped", 32'h01, rd)
        apb(1'b1, A_LF, 32'h3C);
        apb(1'b1, A_LF, 32'hBC);
        waitLvl(1'b1, 1'b1);
        waitLvl(1'b1, 1'b0);
        `CHK("slow high phase", 8 * (HALF0 + 15 * LF_TUNE_STEP_CYC), n)
        testDone;
    end
endmodule
`default_nettype wire
